// >>> rtl/data_space_consts.svh
// Address map, reset values and step sizes of the data space access unit.
// Included by the package and the design modules; definitions only.
`ifndef DATA_SPACE_CONSTS_SVH
`define DATA_SPACE_CONSTS_SVH

`define DS_EA_W         16
`define DS_WREG_COUNT   9
`define DS_WREG_SEL_W   4
`define DS_WREG_RESET   16'h0000
`define DS_WORKING_REG_0_OFS    16'h0000
`define DS_WORKING_REG_1_OFS    16'h0002
`define DS_WORKING_REG_2_OFS    16'h0004
`define DS_WORKING_REG_3_OFS    16'h0006
`define DS_WORKING_REG_4_OFS    16'h8000
`define DS_WORKING_REG_5_OFS    16'h000A
`define DS_WORKING_REG_6_OFS    16'h000C
`define DS_WORKING_REG_7_OFS    16'h000E
`define DS_WORKING_REG_8_OFS    16'h0010
`define DS_SFR_LAST     16'h07FF
`define DS_NEAR_W       13
`define DS_RAM_BASE     16'h0800
`define DS_RAM_LAST     16'h0BFF
`define DS_RAM_WORDS    512
`define DS_RAM_IDX_W    9
`define DS_XY_BOUNDARY  16'h0A00
`define DS_PSV_BIT      15
`define DS_PSV_ADDR_W   15
`define DS_STEP_BYTE    16'h0001
`define DS_STEP_WORD    16'h0002

`endif

// >>> rtl/data_space_pkg.sv
// Types shared by the data space access unit and its address generators.
// Assumes data_space_consts.svh is on the include path.
`include "data_space_consts.svh"

package data_space_pkg;

  typedef logic [`DS_EA_W-1:0] word_t;

  typedef logic [`DS_WREG_SEL_W-1:0] wreg_sel_t;

  typedef enum logic [1:0] {
    MODE_DIRECT13,
    MODE_DIRECT16,
    MODE_INDIRECT,
    MODE_POST_INC
  } addr_mode_t;

endpackage

// >>> rtl/address_gen_unit.sv
// Address generation unit: forms an effective address from a mode and
// computes the post-modified pointer, with modulo and bit-reversed steps.
// Purely combinational; the caller owns the pointer register.
`timescale 1ns/10ps
`default_nettype none
`include "data_space_consts.svh"

module address_gen_unit
  import data_space_pkg::*;
(
  // Request
  input  wire addr_mode_t           mode,
  input  wire logic                 byte_op,
  input  wire word_t                pointer,
  input  wire logic [`DS_NEAR_W-1:0] near_addr,
  input  wire word_t                direct_addr,
  // Addressing options
  input  wire logic                 modulo_en,
  input  wire word_t                modulo_start,
  input  wire word_t                modulo_end,
  input  wire logic                 bitrev_en,
  input  wire word_t                bitrev_mod,
  // Results
  output word_t                     effective_address,
  output word_t                     next_pointer,
  output logic                      pointer_update
);

  function automatic word_t reverse(input word_t v);
    word_t r;
    r = '0;
    for (int i = 0; i < `DS_EA_W; i++) begin
      r[i] = v[`DS_EA_W-1-i];
    end
    return r;
  endfunction

  word_t step;
  word_t sum;

  always_comb begin
    step = byte_op ? `DS_STEP_BYTE : `DS_STEP_WORD;
    sum  = pointer + step;
    unique case (mode)
      MODE_DIRECT13: effective_address = {3'b000, near_addr};
      MODE_DIRECT16: effective_address = direct_addr;
      MODE_INDIRECT: effective_address = pointer;
      MODE_POST_INC: effective_address = pointer;
    endcase
    pointer_update = (mode == MODE_POST_INC);
    if (bitrev_en) begin
      next_pointer = reverse(reverse(pointer) + reverse(bitrev_mod));
    end else if (modulo_en && (sum > modulo_end)) begin
      next_pointer = modulo_start;
    end else begin
      next_pointer = sum;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/data_space_access_unit.sv
// Data space access unit: working registers, 1 Kbyte data RAM, X and Y
// operand paths, address error detection and the program space window.
// Assumes one core clock and a pipeline that issues one access per cycle.
`timescale 1ns/10ps
`default_nettype none
`include "data_space_consts.svh"

module data_space_access_unit
  import data_space_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // X access from the pipeline
  input  wire logic                     x_req,
  input  wire logic                     x_write,
  input  wire logic                     x_byte,
  input  wire addr_mode_t               x_mode,
  input  wire wreg_sel_t                x_ptr_sel,
  input  wire logic [`DS_NEAR_W-1:0]    x_near_addr,
  input  wire word_t                    x_direct_addr,
  input  wire word_t                    x_wdata,
  input  wire logic                     x_load_en,
  input  wire wreg_sel_t                x_load_sel,
  output word_t                         x_rdata_q,
  output logic                          x_rvalid_q,
  // Y operand read
  input  wire logic                     y_req,
  input  wire logic                     mac_class,
  input  wire logic                     y_post_inc,
  input  wire wreg_sel_t                y_ptr_sel,
  output word_t                         y_rdata_q,
  output logic                          y_rvalid_q,
  // Addressing options
  input  wire logic                     x_mod_en,
  input  wire word_t                    x_mod_start,
  input  wire word_t                    x_mod_end,
  input  wire logic                     bitrev_en,
  input  wire word_t                    bitrev_mod,
  input  wire logic                     y_mod_en,
  input  wire word_t                    y_mod_start,
  input  wire word_t                    y_mod_end,
  // Extend operations
  input  wire logic                     ext_req,
  input  wire logic                     ext_sign,
  input  wire wreg_sel_t                ext_sel,
  // Program space window
  output logic                          psv_read,
  output logic [`DS_PSV_ADDR_W-1:0]     psv_addr,
  input  wire word_t                    psv_rdata,
  // Exception logic
  output logic                          addr_trap_q
);

  localparam word_t WREG_OFS [`DS_WREG_COUNT] = '{
    `DS_WORKING_REG_0_OFS, `DS_WORKING_REG_1_OFS, `DS_WORKING_REG_2_OFS, `DS_WORKING_REG_3_OFS,
    `DS_WORKING_REG_4_OFS, `DS_WORKING_REG_5_OFS, `DS_WORKING_REG_6_OFS, `DS_WORKING_REG_7_OFS,
    `DS_WORKING_REG_8_OFS
  };
  localparam wreg_sel_t WREG_CNT = wreg_sel_t'(`DS_WREG_COUNT);

  word_t wreg_q [`DS_WREG_COUNT];
  word_t wreg_d [`DS_WREG_COUNT];
  logic [7:0] ram_lo_q [`DS_RAM_WORDS];
  logic [7:0] ram_hi_q [`DS_RAM_WORDS];

  word_t x_ptr, y_ptr, x_ea, y_ea, x_next_ptr, y_next_ptr;
  logic  x_ptr_upd, y_ptr_upd, x_bitrev;
  word_t x_word, x_rd, y_word;
  logic  x_wreg_hit, x_ram_hit, x_sfr_hit, x_psv_hit, y_hit, y_go;
  wreg_sel_t x_wreg_idx;
  logic  x_misaligned, y_misaligned, ram_we_lo, ram_we_hi;
  logic [`DS_RAM_IDX_W-1:0] x_idx, y_idx;
  word_t x_wd;
  word_t x_rdata_d, y_rdata_d;
  logic  x_rvalid_d, y_rvalid_d, addr_trap_d;

  assign x_ptr = (x_ptr_sel < WREG_CNT) ? wreg_q[x_ptr_sel] : '0;
  assign y_ptr = (y_ptr_sel < WREG_CNT) ? wreg_q[y_ptr_sel] : '0;
  assign x_bitrev = bitrev_en && x_write;

  // Independent generators for the two operand spaces.
  address_gen_unit x_agu (
    .mode              (x_mode),
    .byte_op           (x_byte),
    .pointer           (x_ptr),
    .near_addr         (x_near_addr),
    .direct_addr       (x_direct_addr),
    .modulo_en         (x_mod_en),
    .modulo_start      (x_mod_start),
    .modulo_end        (x_mod_end),
    .bitrev_en         (x_bitrev),
    .bitrev_mod        (bitrev_mod),
    .effective_address (x_ea),
    .next_pointer      (x_next_ptr),
    .pointer_update    (x_ptr_upd)
  );

  address_gen_unit y_agu (
    .mode              (y_post_inc ? MODE_POST_INC : MODE_INDIRECT),
    .byte_op           (1'b0),
    .pointer           (y_ptr),
    .near_addr         ('0),
    .direct_addr       ('0),
    .modulo_en         (y_mod_en),
    .modulo_start      (y_mod_start),
    .modulo_end        (y_mod_end),
    .bitrev_en         (1'b0),
    .bitrev_mod        ('0),
    .effective_address (y_ea),
    .next_pointer      (y_next_ptr),
    .pointer_update    (y_ptr_upd)
  );

  // X address decode and read path.
  always_comb begin
    x_wreg_hit = 1'b0;
    x_wreg_idx = '0;
    for (int i = 0; i < `DS_WREG_COUNT; i++) begin
      if (x_ea[`DS_EA_W-1:1] == WREG_OFS[i][`DS_EA_W-1:1]) begin
        x_wreg_hit = 1'b1;
        x_wreg_idx = wreg_sel_t'(i);
      end
    end
    x_sfr_hit = (x_ea <= `DS_SFR_LAST);
    x_ram_hit = (x_ea >= `DS_RAM_BASE) && (x_ea <= `DS_RAM_LAST);
    x_psv_hit = x_ea[`DS_PSV_BIT] && !x_wreg_hit;
    x_idx = x_ea[`DS_RAM_IDX_W:1];
    if (x_wreg_hit) begin
      x_word = wreg_q[x_wreg_idx];
    end else if (x_ram_hit) begin
      x_word = {ram_hi_q[x_idx], ram_lo_q[x_idx]};
    end else if (x_psv_hit) begin
      x_word = psv_rdata;
    end else if (x_sfr_hit) begin
      x_word = '0;
    end else begin
      x_word = '0;
    end
    if (x_byte) begin
      x_rd = {8'h00, x_ea[0] ? x_word[15:8] : x_word[7:0]};
    end else begin
      x_rd = x_word;
    end
    x_misaligned = !x_byte && x_ea[0];
    psv_read = x_req && !x_write && x_psv_hit;
    psv_addr = x_ea[`DS_PSV_ADDR_W-1:0];
  end

  // X write lanes; a misaligned word write never reaches storage.
  always_comb begin
    ram_we_lo = 1'b0;
    ram_we_hi = 1'b0;
    if (x_req && x_write && !x_misaligned) begin
      ram_we_lo = x_byte ? !x_ea[0] : 1'b1;
      ram_we_hi = x_byte ? x_ea[0] : 1'b1;
    end
    x_wd = x_byte ? {x_wdata[7:0], x_wdata[7:0]} : x_wdata;
  end

  // Y operand read: only for the multiply-accumulate class, Y half only.
  always_comb begin
    y_go = y_req && mac_class;
    y_hit = (y_ea >= `DS_XY_BOUNDARY) && (y_ea <= `DS_RAM_LAST);
    y_idx = y_ea[`DS_RAM_IDX_W:1];
    y_word = y_hit ? {ram_hi_q[y_idx], ram_lo_q[y_idx]} : '0;
    y_misaligned = y_go && y_ea[0];
  end

  // Working register next values, lowest priority first.
  always_comb begin
    for (int i = 0; i < `DS_WREG_COUNT; i++) begin
      wreg_d[i] = wreg_q[i];
    end
    if (y_go && y_ptr_upd && (y_ptr_sel < WREG_CNT)) begin
      wreg_d[y_ptr_sel] = y_next_ptr;
    end
    if (x_req && x_ptr_upd && (x_ptr_sel < WREG_CNT)) begin
      wreg_d[x_ptr_sel] = x_next_ptr;
    end
    if (x_wreg_hit && (ram_we_lo || ram_we_hi)) begin
      if (ram_we_lo) begin
        wreg_d[x_wreg_idx][7:0] = x_wd[7:0];
      end
      if (ram_we_hi) begin
        wreg_d[x_wreg_idx][15:8] = x_wd[15:8];
      end
    end
    if (x_req && !x_write && x_load_en && (x_load_sel < WREG_CNT)) begin
      if (x_byte) begin
        wreg_d[x_load_sel][7:0] = x_rd[7:0];
      end else begin
        wreg_d[x_load_sel] = x_rd;
      end
    end
    if (ext_req && (ext_sel < WREG_CNT)) begin
      if (ext_sign) begin
        wreg_d[ext_sel][15:8] = {8{wreg_q[ext_sel][7]}};
      end else begin
        wreg_d[ext_sel][15:8] = 8'h00;
      end
    end
  end

  // Read answers and the trap pulse.
  always_comb begin
    x_rvalid_d = x_req && !x_write;
    x_rdata_d = x_rvalid_d ? x_rd : x_rdata_q;
    y_rvalid_d = y_go;
    y_rdata_d = y_go ? y_word : y_rdata_q;
    addr_trap_d = (x_req && x_misaligned) || y_misaligned;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `DS_WREG_COUNT; i++) begin
        wreg_q[i] <= `DS_WREG_RESET;
      end
      x_rdata_q <= '0;
      x_rvalid_q <= 1'b0;
      y_rdata_q <= '0;
      y_rvalid_q <= 1'b0;
      addr_trap_q <= 1'b0;
    end else begin
      for (int i = 0; i < `DS_WREG_COUNT; i++) begin
        wreg_q[i] <= wreg_d[i];
      end
      x_rdata_q <= x_rdata_d;
      x_rvalid_q <= x_rvalid_d;
      y_rdata_q <= y_rdata_d;
      y_rvalid_q <= y_rvalid_d;
      addr_trap_q <= addr_trap_d;
    end
  end

  // Data RAM covers both X and Y halves; all writes come over X.
  always_ff @(posedge clock) begin
    if (x_ram_hit && ram_we_lo) begin
      ram_lo_q[x_idx] <= x_wd[7:0];
    end
    if (x_ram_hit && ram_we_hi) begin
      ram_hi_q[x_idx] <= x_wd[15:8];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_bad_write;
    x_req && x_write && !x_byte && x_ea[0];
  endsequence

  sequence seq_trap_pulse;
    addr_trap_q ##1 !addr_trap_q;
  endsequence

  a_trap_next_cycle: assert property (
    x_req && !x_byte && x_ea[0] |=> addr_trap_q)
    else $error("Misaligned word access did not trap next cycle.");

  a_trap_single_pulse: assert property (
    (x_req && x_misaligned) ##1 !(x_req && x_misaligned) && !y_misaligned
    |-> seq_trap_pulse)
    else $error("Trap request was not a single-cycle pulse.");

  a_write_suppressed: assert property (
    seq_bad_write |-> !ram_we_lo && !ram_we_hi ##1 addr_trap_q)
    else $error("Misaligned write reached storage or missed its trap.");

  a_byte_lane_only: assert property (
    x_req && x_write && x_byte |-> (ram_we_lo != ram_we_hi)
    && (ram_we_hi == x_ea[0]))
    else $error("Byte write touched the wrong lane.");

  a_byte_read_low: assert property (
    x_req && !x_write && x_byte |=> x_rvalid_q && x_rdata_q[15:8] == 8'h00
    && x_rdata_q[7:0] == ($past(x_ea[0]) ? $past(x_word[15:8])
    : $past(x_word[7:0])))
    else $error("Byte read did not land on the low lane.");

  a_post_inc_step: assert property (
    x_req && !x_write && x_mode == MODE_POST_INC && !x_mod_en
    && x_ptr_sel < WREG_CNT && !x_load_en && !ext_req && !y_req
    |=> wreg_q[$past(x_ptr_sel)] == $past(x_ptr)
    + ($past(x_byte) ? `DS_STEP_BYTE : `DS_STEP_WORD))
    else $error("Post-increment step size wrong.");

  a_sign_extend: assert property (
    ext_req && ext_sign && ext_sel < WREG_CNT
    |=> wreg_q[$past(ext_sel)][15:8] == {8{$past(wreg_q[ext_sel][7])}})
    else $error("Sign extension gave wrong high byte.");

  a_zero_extend: assert property (
    ext_req && !ext_sign && ext_sel < WREG_CNT
    |=> wreg_q[$past(ext_sel)][15:8] == 8'h00)
    else $error("Zero extension left high byte set.");

  a_unimpl_zero: assert property (
    x_req && !x_write && !x_wreg_hit && !x_ram_hit && !x_ea[`DS_PSV_BIT]
    |=> x_rdata_q == '0)
    else $error("Unimplemented address read nonzero.");

  a_y_mac_only: assert property (
    y_rvalid_q |-> $past(y_req && mac_class))
    else $error("Y read answered outside the multiply class.");

  a_psv_route: assert property (
    x_req && !x_write && x_ea[`DS_PSV_BIT] && !x_wreg_hit
    |-> psv_read ##1 x_rdata_q == ($past(x_byte)
    ? {8'h00, ($past(x_ea[0]) ? $past(psv_rdata[15:8])
    : $past(psv_rdata[7:0]))} : $past(psv_rdata)))
    else $error("Upper half read not routed to program window.");

endmodule

`default_nettype wire

// >>> bench/psv_window_model.sv
// Program space window model for the upper half of data space.
// Assumes psv_read and psv_addr are driven in the cycle of the read.
`timescale 1ns/10ps
`default_nettype none
module psv_window_model (
  // Window request
  input  wire logic        psv_read,
  input  wire logic [14:0] psv_addr,
  // Answer
  output logic [15:0]      psv_rdata
);
  logic [15:0] ans;
  logic [15:0] last_q = 16'h0000;
  assign ans = {1'b0, psv_addr} ^ 16'hA5C3;
  // Outside a read the bus shows the inverse of the last answer.
  assign psv_rdata = psv_read ? ans : ~last_q;
  always @* if (psv_read) last_q = ans;
endmodule
`default_nettype wire

// >>> bench/data_space_access_unit_tb_top.sv
// Bench for the data space access unit with a reference model.
// Assumes the design package and the program window model are compiled.
`timescale 1ns/10ps
`default_nettype none
module data_space_access_unit_tb_top;
  import data_space_pkg::*;
  logic        clock = 0, rst = 1, x_req = 0, x_write = 0, x_byte = 0;
  logic        x_load_en = 0, x_mod_en = 0, y_mod_en = 0, y_req = 0;
  logic        mac_class = 0, y_post_inc = 0, ext_req = 0, ext_sign = 0;
  logic        bitrev_en = 0;
  word_t       bitrev_mod = 0;
  logic        x_rvalid_q, y_rvalid_q, psv_read, addr_trap_q;
  addr_mode_t  x_mode = MODE_DIRECT16;
  wreg_sel_t   x_ptr_sel = 0, x_load_sel = 0, y_ptr_sel = 0, ext_sel = 0;
  logic [12:0] x_near_addr = 0;
  logic [14:0] psv_addr;
  word_t       x_direct_addr = 0, x_wdata = 0, x_rdata_q, y_rdata_q;
  word_t       x_mod_start = 0, x_mod_end = 0, y_mod_start = 0;
  word_t       y_mod_end = 0, psv_rdata, a, d;
  word_t       wr[9];
  logic [7:0]  mem[int];
  integer      fails = 0, tests_run = 0, cyc = 0, seed = 32'h46c0013b;

  data_space_access_unit i_dut (.clock, .rst, .x_req, .x_write, .x_byte,
    .x_mode, .x_ptr_sel, .x_near_addr, .x_direct_addr, .x_wdata,
    .x_load_en, .x_load_sel, .x_rdata_q, .x_rvalid_q, .y_req, .mac_class,
    .y_post_inc, .y_ptr_sel, .y_rdata_q, .y_rvalid_q, .x_mod_en,
    .x_mod_start, .x_mod_end, .bitrev_en, .bitrev_mod,
    .y_mod_en, .y_mod_start, .y_mod_end, .ext_req, .ext_sign, .ext_sel,
    .psv_read, .psv_addr, .psv_rdata, .addr_trap_q);
  psv_window_model i_psv (.psv_read, .psv_addr, .psv_rdata);

  function automatic word_t rofs(int i);
    return (i == 4) ? 16'h8000 : 16'(i * 2);
  endfunction

  function automatic word_t rv(word_t v);
    word_t r;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    return r;
  endfunction

  function automatic logic in_ram(word_t e);
    return e >= 16'h0800 && e <= 16'h0BFF;
  endfunction

  function automatic word_t mw(word_t e);
    e[0] = 1'b0;
    for (int i = 0; i < 9; i++) if (e == rofs(i)) return wr[i];
    if (in_ram(e)) return {mem[e+1], mem[e]};
    if (e[15]) return {1'b0, e[14:0]} ^ 16'hA5C3;
    return 16'h0000;
  endfunction

  function automatic void mwr(word_t e, logic b, word_t v);
    if (!b && e[0]) return;
    for (int i = 0; i < 9; i++) if ({e[15:1], 1'b0} == rofs(i)) begin
      if (!b) wr[i] = v;
      else if (e[0]) wr[i][15:8] = v[7:0];
      else wr[i][7:0] = v[7:0];
    end
    if (in_ram(e)) mem[e] = e[0] || b ? v[7:0] : v[7:0];
    if (in_ram(e) && !b) mem[e+1] = v[15:8];
  endfunction

  task automatic chk(string n, word_t e, word_t g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic xa(logic w, logic b, addr_mode_t m, word_t ad,
                    word_t v = 0, logic ld = 0, wreg_sel_t ls = 0,
                    wreg_sel_t ps = 0);
    word_t e, x, q;
    @(posedge clock);
    #1;
    chk("trap idle", 16'h0000, 16'(addr_trap_q));
    e = m == MODE_DIRECT13 ? {3'b000, ad[12:0]} : m == MODE_DIRECT16 ? ad
        : wr[ps];
    {x_req, x_write, x_byte, x_mode, x_load_en} = {1'b1, w, b, m, ld};
    {x_near_addr, x_direct_addr, x_wdata} = {ad[12:0], ad, v};
    {x_load_sel, x_ptr_sel} = {ls, ps};
    @(posedge clock);
    #1;
    x_req = 0;
    x = mw(e);
    if (b) x = e[0] ? {8'h00, x[15:8]} : {8'h00, x[7:0]};
    if (m == MODE_POST_INC) begin
      q = wr[ps] + (b ? 16'h0001 : 16'h0002);
      if (bitrev_en && w) wr[ps] = rv(rv(wr[ps]) + rv(bitrev_mod));
      else wr[ps] = (x_mod_en && q > x_mod_end) ? x_mod_start : q;
    end
    if (w) mwr(e, b, v);
    else begin
      chk("x_rdata", x, x_rdata_q);
      chk("x_rvalid", 16'h0001, 16'(x_rvalid_q));
      if (ld && b) wr[ls][7:0] = x[7:0];
      else if (ld) wr[ls] = x;
    end
    chk("trap", 16'(!b && e[0]), 16'(addr_trap_q));
  endtask

  task automatic ya(logic mc, wreg_sel_t p);
    word_t e, q;
    @(posedge clock);
    #1;
    {y_req, mac_class, y_ptr_sel, y_post_inc} = {1'b1, mc, p, 1'b1};
    e = wr[p];
    @(posedge clock);
    #1;
    y_req = 0;
    chk("y_rvalid", 16'(mc), 16'(y_rvalid_q));
    if (mc) begin
      chk("y_rdata", e >= 16'h0A00 && in_ram(e) ? mw(e) : 0, y_rdata_q);
      q = wr[p] + 16'h0002;
      wr[p] = (y_mod_en && q > y_mod_end) ? y_mod_start : q;
    end
  endtask

  task automatic ex(logic s, wreg_sel_t r);
    @(posedge clock);
    #1;
    {ext_req, ext_sign, ext_sel} = {1'b1, s, r};
    @(posedge clock);
    #1;
    ext_req = 0;
    wr[r][15:8] = s ? {8{wr[r][7]}} : 8'h00;
    xa(0, 0, MODE_DIRECT16, rofs(r));
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    foreach (wr[i]) wr[i] = 16'h0000;
    repeat (8) @(posedge clock);
    #1 rst = 0;
    for (int i = 0; i < 9; i++) xa(0, 0, MODE_DIRECT16, rofs(i));
    for (int i = 0; i < 9; i++) xa(1, 0, MODE_DIRECT16, rofs(i), $random(seed));
    for (int i = 0; i < 12; i++) begin
      a = 16'h0800 | (16'($random(seed)) & 16'h03FE);
      d = $random(seed);
      xa(1, 0, MODE_DIRECT16, a, d);
      xa(1, 1, MODE_DIRECT16, a | 16'h0001, d ^ 16'h005A);
      xa(0, 0, MODE_DIRECT16, a);
      xa(0, 1, MODE_DIRECT16, a | 16'h0001);
      xa(1, 0, MODE_DIRECT16, a | 16'h0001, ~d);
      xa(0, 0, MODE_DIRECT16, a);
      xa(0, 0, MODE_DIRECT16, a | 16'h0001, 0, 1, 5);
      xa(0, 0, MODE_DIRECT16, 16'h000A);
    end
    xa(1, 1, MODE_DIRECT16, 16'h0007, 16'h00C3);
    xa(0, 0, MODE_DIRECT16, 16'h0006);
    xa(1, 0, MODE_DIRECT16, 16'h0800, 16'h1234);
    xa(1, 0, MODE_DIRECT16, 16'h0802, 16'h5678);
    xa(1, 0, MODE_DIRECT16, 16'h0002, 16'h0800);
    xa(0, 1, MODE_POST_INC, 0, 0, 1, 6, 1);
    xa(0, 1, MODE_POST_INC, 0, 0, 0, 0, 1);
    xa(0, 0, MODE_POST_INC, 0, 0, 0, 0, 1);
    xa(0, 0, MODE_DIRECT16, 16'h0002);
    xa(0, 0, MODE_DIRECT16, 16'h000C);
    xa(1, 0, MODE_DIRECT16, 16'h0002, 16'h0802);
    {x_mod_en, x_mod_start, x_mod_end} = {1'b1, 16'h0800, 16'h0803};
    xa(0, 0, MODE_POST_INC, 0, 0, 0, 0, 1);
    xa(0, 0, MODE_INDIRECT, 0, 0, 0, 0, 1);
    x_mod_en = 0;
    xa(1, 0, MODE_DIRECT16, 16'h000E, 16'h1280);
    ex(1, 7);
    ex(0, 7);
    xa(1, 0, MODE_DIRECT16, 16'h0010, 16'hAB7F);
    ex(1, 8);
    xa(1, 0, MODE_DIRECT16, 16'h0100, 16'hFFFF);
    xa(0, 0, MODE_DIRECT16, 16'h0100);
    xa(0, 0, MODE_DIRECT16, 16'h07FE);
    xa(0, 0, MODE_DIRECT16, 16'h1000);
    xa(0, 1, MODE_DIRECT16, 16'h1FFF);
    xa(0, 0, MODE_DIRECT16, 16'h8002);
    xa(0, 0, MODE_DIRECT16, 16'hF0A4);
    xa(1, 0, MODE_DIRECT16, 16'h8000, 16'h4C4C);
    xa(0, 0, MODE_DIRECT16, 16'h8000);
    xa(1, 0, MODE_DIRECT13, 16'h0804, 16'h9A9A);
    xa(0, 0, MODE_DIRECT13, 16'hE804);
    xa(1, 0, MODE_DIRECT16, 16'h0A00, 16'h0F1E);
    xa(1, 0, MODE_DIRECT16, 16'h0A02, 16'h2D3C);
    xa(1, 0, MODE_DIRECT16, 16'h0004, 16'h0A00);
    fork
      xa(0, 0, MODE_DIRECT16, 16'h0800);
      ya(1, 2);
    join
    ya(0, 2);
    {y_mod_en, y_mod_start, y_mod_end} = {1'b1, 16'h0A00, 16'h0A03};
    ya(1, 2);
    xa(0, 0, MODE_DIRECT16, 16'h0004);
    xa(1, 0, MODE_DIRECT16, 16'h0006, 16'h0800);
    {bitrev_en, bitrev_mod} = {1'b1, 16'h0008};
    xa(1, 0, MODE_POST_INC, 0, 16'h7777, 0, 0, 3);
    bitrev_en = 0;
    xa(0, 0, MODE_DIRECT16, 16'h0006);
    xa(0, 0, MODE_DIRECT16, 16'h0800);
    give_verdict();
  end
endmodule
`default_nettype wire
